/* File: rtl/sdram_mode_power_control_defs.vh */
// Constants for the SDRAM mode power block
`ifndef SDRAM_MODE_POWER_CONTROL_DEFS_VH
`define SDRAM_MODE_POWER_CONTROL_DEFS_VH
// Register indices; byte address is four times the index
`define IDX_STATUS      30'h0000_0000
`define IDX_GEN_CTRL    30'h0000_0001
`define IDX_GEN_CTRL2   30'h0000_0002
`define GC_RESET        32'h8814_8200
`define GC2_RESET       32'h0003_0200
`define HTRANS_NONSEQ   2'h2
`define HSIZE_WORD      3'h2
// General control fields
`define GC_GO_OPER      0
`define GC_GO_PARKED    1
`define GC_READY1       2
`define GC_READY2       3
`define GC_PD_SRC_HI    5
`define GC_PD_SRC_LO    4
`define GC_PARK         6
`define GC_SUS_INHIBIT  8
`define GC_SUS_FLOAT    9
`define GC_SUS_DRAIN    10
`define GC_DYN_SR       11
`define GC_DELAY_HI     15
`define GC_DELAY_LO     12
`define GC_SKIP_SR      19
`define GC_SETTLE_HI    23
`define GC_SETTLE_LO    20
`define GC_DLLR_HI      27
`define GC_DLLR_LO      24
`define GC_DLOCK_HI     31
`define GC_DLOCK_LO     28
// Second control fields
`define GC2_DROP_EMPTY  9
`define GC2_ALT_SUS     10
`define GC2_DBG_ROT     30
`define GC2_SETUP_DONE  31
// Power-down source encodings
`define PD_SRC_PIN      2'h0
`define PD_SRC_CPU      2'h1
`define PD_SRC_BOTH     2'h2
// Timing multipliers as shifts
`define SH_DELAY        2'h1
`define SH_SETTLE       2'h0
`define SH_DLL          2'h2
`define CNT_ZERO        11'h000
`define CNT_ONE         11'h001
`define DBG_LAST_TICK   4'hF
// Init phases
`define PH_SETTLE       2'h0
`define PH_DLLR         2'h1
`define PH_DLOCK        2'h2
`endif

/* File: rtl/sdram_mode_power_control.v */
// SDRAM mode machine, power control and status behind AHB-Lite
//
// The implementer's own choice: the AHB-Lite slave port.
`include "sdram_mode_power_control_defs.vh"

module sdram_mode_power_control (
    input  wire        ref_clk_in,
    input  wire        rst_b_in,
    input  wire        ce_in,
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output wire        hreadyout_out,
    output wire        hresp_out,
    output reg  [31:0] hrdata_out,
    input  wire        hardware_stop_input_in,
    input  wire        suspend_status_input_in,
    input  wire        alt_clock_input_pin_in,
    input  wire        cpu_s3_in,
    input  wire        display_shutter_in,
    input  wire        cpu_special_cycle_in,
    input  wire        sysmem_busy_in,
    input  wire        fb_busy_in,
    input  wire        seq_busy_in,
    input  wire        arb_busy_in,
    input  wire        chan_a_busy_in,
    input  wire        chan_a_seq_busy_in,
    input  wire        chan_a_arb_busy_in,
    input  wire        client_req_in,
    output wire        client_accept_out,
    input  wire        side_wr_in,
    input  wire [3:0]  side_be_in,
    output wire        side_wr_out,
    output wire        cke_out,
    output wire        mem_oe_b_out,
    output reg         dll_reset_out,
    output reg         selfref_enter_out,
    output reg         selfref_exit_out,
    output wire [6:0]  mode_state_out,
    output reg  [1:0]  debug_group_out,
    output reg  [7:0]  debug_bus_out
);

    localparam [6:0] S_POWERON = 7'h01;
    localparam [6:0] S_INIT    = 7'h02;
    localparam [6:0] S_OPER    = 7'h04;
    localparam [6:0] S_PARKING = 7'h08;
    localparam [6:0] S_PARKED  = 7'h10;
    localparam [6:0] S_WAKE    = 7'h20;
    localparam [6:0] S_DYNSR   = 7'h40;
    localparam       NSYNC     = 5;

    reg  [6:0]       state_q;
    reg  [1:0]       phase_q;
    reg  [10:0]      cnt_q;
    reg              dyn_arm_q;
    reg              sw_park_q;
    reg              selfref_q;
    reg              exit_done_q;
    reg  [31:0]      gc_q;
    reg  [31:0]      gc2_q;
    reg              wr_pend_q;
    reg  [29:0]      wr_idx_q;
    reg  [3:0]       dbg_tick_q;
    reg  [NSYNC-1:0] sync1_q;
    reg  [NSYNC-1:0] sync2_q;

    wire [NSYNC-1:0] raw_pins;
    wire             stop_s;
    wire             sus_pin_s;
    wire             alt_pin_s;
    wire             s3_s;
    wire             shutter_s;
    wire             addr_ok;
    wire             rd_take;
    wire             wr_gc;
    wire             go_oper_p;
    wire             go_park_p;
    wire             park_p;
    wire             sus_status;
    reg              pd_event;
    wire             dyn_cond;
    wire             drained;
    wire [31:0]      status_w;
    wire             ready1;
    wire             ready2;
    wire             float_pins;

    // Timer load: field times a power of four
    function [10:0] scaled;
        input [3:0] field;
        input [1:0] sh;
        begin
            scaled = {7'h00, field} << ({1'b0, sh} << 1);
        end
    endfunction

    function [31:0] read_mux;
        input [29:0] idx;
        input [31:0] st;
        input [31:0] g1;
        input [31:0] g2;
        begin
            case (idx)
                `IDX_STATUS:    read_mux = st;
                `IDX_GEN_CTRL:  read_mux = g1;
                `IDX_GEN_CTRL2: read_mux = g2;
                default:        read_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // Asynchronous pins pass two flops before use
    assign raw_pins = {display_shutter_in, cpu_s3_in, alt_clock_input_pin_in,
                       suspend_status_input_in, hardware_stop_input_in};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else if (ce_in) begin
                    sync1_q[gi] <= raw_pins[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    assign stop_s    = sync2_q[0];
    assign sus_pin_s = sync2_q[1];
    assign alt_pin_s = sync2_q[2];
    assign s3_s      = sync2_q[3];
    assign shutter_s = sync2_q[4];

    // Bus: zero wait states; clock enable low stalls the bus
    assign hreadyout_out = ce_in;
    assign hresp_out     = 1'b0;
    assign addr_ok = hsel_in && hready_in && ce_in && (htrans_in == `HTRANS_NONSEQ)
                     && (hsize_in == `HSIZE_WORD);
    assign rd_take = addr_ok && !hwrite_in;
    assign wr_gc   = wr_pend_q && ce_in && (wr_idx_q == `IDX_GEN_CTRL);
    assign go_oper_p = wr_gc && hwdata_in[`GC_GO_OPER];
    assign go_park_p = wr_gc && hwdata_in[`GC_GO_PARKED];
    assign park_p    = wr_gc && hwdata_in[`GC_PARK];

    assign status_w = {12'h000,
                       ~chan_a_arb_busy_in,
                       ~chan_a_seq_busy_in,
                       ~chan_a_busy_in,
                       ~(state_q[1] | state_q[5]),
                       13'h0000,
                       ~arb_busy_in & ~fb_busy_in,
                       ~seq_busy_in & ~fb_busy_in,
                       ~sysmem_busy_in & ~fb_busy_in};

    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_pend_q  <= 1'b0;
            wr_idx_q   <= `IDX_STATUS;
            hrdata_out <= 32'h0000_0000;
            gc_q       <= `GC_RESET;
            gc2_q      <= `GC2_RESET;
        end else if (ce_in) begin
            wr_pend_q <= addr_ok && hwrite_in;
            wr_idx_q  <= haddr_in[31:2];
            if (rd_take) begin
                hrdata_out <= read_mux(haddr_in[31:2], status_w, gc_q, gc2_q);
            end
            // Status index has no write path
            if (wr_gc) begin
                gc_q <= hwdata_in;
            end
            if (wr_pend_q && (wr_idx_q == `IDX_GEN_CTRL2)) begin
                gc2_q <= hwdata_in;
            end
        end
    end

    // Alternate pin carries an active-low suspend status
    assign sus_status = gc2_q[`GC2_ALT_SUS] ? ~alt_pin_s : sus_pin_s;

    always @* begin
        case (gc_q[`GC_PD_SRC_HI:`GC_PD_SRC_LO])
            `PD_SRC_PIN:  pd_event = stop_s | sus_status;
            `PD_SRC_CPU:  pd_event = cpu_special_cycle_in;
            `PD_SRC_BOTH: pd_event = stop_s | sus_status | cpu_special_cycle_in;
            default:      pd_event = 1'b0;
        endcase
    end

    assign dyn_cond = gc_q[`GC_DYN_SR] && s3_s && shutter_s;
    assign drained  = ~sysmem_busy_in & ~fb_busy_in & ~chan_a_busy_in;
    assign ready1   = gc_q[`GC_READY1];
    assign ready2   = gc_q[`GC_READY2];

    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q           <= S_POWERON;
            phase_q           <= `PH_SETTLE;
            cnt_q             <= `CNT_ZERO;
            dyn_arm_q         <= 1'b0;
            sw_park_q         <= 1'b0;
            selfref_q         <= 1'b0;
            exit_done_q       <= 1'b0;
            dll_reset_out     <= 1'b0;
            selfref_enter_out <= 1'b0;
            selfref_exit_out  <= 1'b0;
        end else if (ce_in) begin
            selfref_enter_out <= 1'b0;
            selfref_exit_out  <= 1'b0;
            case (state_q)
                S_POWERON: begin
                    if (go_oper_p) begin
                        state_q <= S_INIT;
                        phase_q <= `PH_SETTLE;
                        cnt_q   <= scaled(gc_q[`GC_SETTLE_HI:`GC_SETTLE_LO],
                                          `SH_SETTLE) << 4;
                    end else if (go_park_p) begin
                        state_q   <= S_PARKED;
                        selfref_q <= 1'b1;
                    end
                end
                S_INIT: begin
                    // Timers wait for clocks ready
                    if (ready1) begin
                        if (cnt_q != `CNT_ZERO) begin
                            cnt_q <= cnt_q - `CNT_ONE;
                        end else if (phase_q == `PH_SETTLE) begin
                            phase_q       <= `PH_DLLR;
                            dll_reset_out <= 1'b1;
                            cnt_q <= scaled(gc_q[`GC_DLLR_HI:`GC_DLLR_LO],
                                            `SH_DLL) << 2;
                        end else if (phase_q == `PH_DLLR) begin
                            phase_q       <= `PH_DLOCK;
                            dll_reset_out <= 1'b0;
                            cnt_q <= scaled(gc_q[`GC_DLOCK_HI:`GC_DLOCK_LO],
                                            `SH_DLL) << 2;
                        end else begin
                            state_q <= S_OPER;
                        end
                    end
                end
                S_OPER: begin
                    if (park_p || (pd_event && !gc_q[`GC_SUS_INHIBIT])) begin
                        state_q   <= S_PARKING;
                        sw_park_q <= park_p;
                        dyn_arm_q <= 1'b0;
                    end else if (dyn_cond) begin
                        if (!dyn_arm_q) begin
                            dyn_arm_q <= 1'b1;
                            cnt_q <= scaled(gc_q[`GC_DELAY_HI:`GC_DELAY_LO],
                                            `SH_DELAY);
                        end else if (cnt_q != `CNT_ZERO) begin
                            cnt_q <= cnt_q - `CNT_ONE;
                        end else begin
                            state_q           <= S_DYNSR;
                            dyn_arm_q         <= 1'b0;
                            selfref_q         <= 1'b1;
                            selfref_enter_out <= 1'b1;
                        end
                    end else begin
                        dyn_arm_q <= 1'b0;
                    end
                end
                S_PARKING: begin
                    // Parking always drains; suspend drains only if asked
                    if (drained || !(sw_park_q || gc_q[`GC_SUS_DRAIN])) begin
                        state_q <= S_PARKED;
                        if (sw_park_q || !gc_q[`GC_SKIP_SR]) begin
                            selfref_q         <= 1'b1;
                            selfref_enter_out <= 1'b1;
                        end
                    end
                end
                S_PARKED: begin
                    if (!stop_s) begin
                        state_q     <= S_WAKE;
                        exit_done_q <= 1'b0;
                    end
                end
                S_WAKE: begin
                    if (ready2) begin
                        if (!exit_done_q) begin
                            exit_done_q      <= 1'b1;
                            selfref_exit_out <= selfref_q;
                            selfref_q        <= 1'b0;
                            cnt_q <= scaled(gc_q[`GC_DLOCK_HI:`GC_DLOCK_LO],
                                            `SH_DLL) << 2;
                        end else if (cnt_q != `CNT_ZERO) begin
                            cnt_q <= cnt_q - `CNT_ONE;
                        end else begin
                            state_q <= S_OPER;
                        end
                    end
                end
                S_DYNSR: begin
                    if (!dyn_cond) begin
                        state_q          <= S_OPER;
                        selfref_q        <= 1'b0;
                        selfref_exit_out <= 1'b1;
                    end
                end
                default: begin
                    state_q <= S_POWERON;
                end
            endcase
        end
    end

    // Pins float until clocks are ready, and in suspend if enabled
    assign float_pins = ((state_q[0] | state_q[1]) & ~ready1)
                      | (state_q[5] & ~ready2)
                      | (state_q[4] & gc_q[`GC_SUS_FLOAT]);
    assign mem_oe_b_out = float_pins;
    assign cke_out      = ~float_pins & ~selfref_q;
    assign mode_state_out = state_q;

    // Requests pass only when operating and setup is done
    assign client_accept_out = client_req_in && gc2_q[`GC2_SETUP_DONE]
                               && state_q[2];
    assign side_wr_out = side_wr_in && gc2_q[`GC2_SETUP_DONE] && state_q[2]
                         && !(gc2_q[`GC2_DROP_EMPTY] && (side_be_in == 4'h0));

    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dbg_tick_q      <= 4'h0;
            debug_group_out <= 2'h0;
            debug_bus_out   <= 8'h00;
        end else if (ce_in) begin
            if (gc2_q[`GC2_DBG_ROT]) begin
                dbg_tick_q <= dbg_tick_q + 4'h1;
                if (dbg_tick_q == `DBG_LAST_TICK) begin
                    debug_group_out <= debug_group_out + 2'h1;
                end
            end else begin
                dbg_tick_q <= 4'h0;
            end
            case (debug_group_out)
                2'h0:    debug_bus_out <= {1'b0, state_q};
                2'h1:    debug_bus_out <= cnt_q[7:0];
                2'h2:    debug_bus_out <= {status_w[19:16], 1'b0, status_w[2:0]};
                default: debug_bus_out <= {phase_q, selfref_q, exit_done_q,
                                           dyn_arm_q, sw_park_q, pd_event, dyn_cond};
            endcase
        end
    end

endmodule // sdram_mode_power_control

/* File: dv/sdram_dev_model.sv */
// Behavioural SDRAM device side: tracks self-refresh and flags protocol slips
module sdram_dev_model (
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire        cke_in,
    input  wire        enter_in,
    input  wire        exit_in,
    output logic       in_sr_out,
    output logic [7:0] enters_out,
    output logic       err_out
);
    timeunit 1ns;
    timeprecision 100ps;
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            in_sr_out <= 1'b0;
            enters_out <= 8'h00;
            err_out <= 1'b0;
        end else begin
            if (enter_in) begin
                in_sr_out <= 1'b1;
                enters_out <= enters_out + 8'h01;
            end
            if (exit_in) begin
                in_sr_out <= 1'b0;
            end
            // Parts lose data if CKE rises before the exit command
            if ((in_sr_out && cke_in && !exit_in) || (enter_in && in_sr_out)) begin
                err_out <= 1'b1;
            end
        end
    end
endmodule // sdram_dev_model

/* File: dv/sdram_mode_power_control_monitor.sv */
// Port assertions for the SDRAM mode power block
module sdram_mode_power_control_monitor (
    input wire       ref_clk_in,
    input wire       rst_b_in,
    input wire       ce_in,
    input wire       client_req_in,
    input wire       side_wr_in,
    input wire       hreadyout_out,
    input wire       hresp_out,
    input wire       client_accept_out,
    input wire       side_wr_out,
    input wire       cke_out,
    input wire       mem_oe_b_out,
    input wire       dll_reset_out,
    input wire       selfref_enter_out,
    input wire       selfref_exit_out,
    input wire [6:0] mode_state_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] PON = 7'h01, INIT = 7'h02, OPER = 7'h04, PKG = 7'h08;
    logic [9:0] dll_q;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dll_q <= 10'h000;
        end else begin
            dll_q <= dll_reset_out ? dll_q + 10'h001 : 10'h000;
        end
    end
    a_accept_gate: assert property (client_accept_out |-> client_req_in && mode_state_out == OPER)
        else $error("accept gated");
    a_side_gate: assert property (side_wr_out |-> side_wr_in && mode_state_out == OPER)
        else $error("side gated");
    a_poweron_float: assert property (mode_state_out == PON |-> !cke_out && mem_oe_b_out)
        else $error("pins driven at power-on");
    a_oper_drive: assert property (mode_state_out == OPER |-> cke_out && !mem_oe_b_out)
        else $error("pins floated operating");
    a_state_onehot: assert property ($onehot(mode_state_out))
        else $error("not one-hot");
    a_init_entry: assert property ($rose(mode_state_out == INIT) |-> $past(mode_state_out) == PON)
        else $error("bad init entry");
    a_park_entry: assert property ($rose(mode_state_out == PKG) |-> $past(mode_state_out) == OPER)
        else $error("bad park entry");
    a_dll_width: assert property ($fell(dll_reset_out) |-> dll_q[5:0] == 6'h01 && dll_q > 10'h040)
        else $error("bad dll width");
    a_enter_pulse: assert property (selfref_enter_out |=> !selfref_enter_out)
        else $error("long entry pulse");
    a_exit_pulse: assert property (selfref_exit_out |=> !selfref_exit_out)
        else $error("long exit pulse");
    a_ready_follow: assert property (hreadyout_out == ce_in && !hresp_out)
        else $error("bad ready or resp");
endmodule // sdram_mode_power_control_monitor

bind sdram_mode_power_control sdram_mode_power_control_monitor mon_u (
    .ref_clk_in(ref_clk_in),.rst_b_in(rst_b_in),.ce_in(ce_in),
    .client_req_in(client_req_in),.side_wr_in(side_wr_in),.hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),.client_accept_out(client_accept_out),.side_wr_out(side_wr_out),
    .cke_out(cke_out),.mem_oe_b_out(mem_oe_b_out),.dll_reset_out(dll_reset_out),
    .selfref_enter_out(selfref_enter_out),.selfref_exit_out(selfref_exit_out),
    .mode_state_out(mode_state_out)
);

/* File: dv/sdram_mode_power_control_tb.sv */
// Self-checking bench for the SDRAM mode power block
`include "sdram_mode_power_control_defs.vh"
module sdram_mode_power_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] PON = 7'h01, INIT = 7'h02, OPER = 7'h04, PKG = 7'h08;
    localparam logic [6:0] PKD = 7'h10, WAKE = 7'h20, DSR = 7'h40;
    logic        clk, rst_b, ce, hsel, hwr, hrdy, hresp, stop, cpu_sc, s3, shut;
    logic        creq, cacc, swr, swr_o, cke, oe_b, dll, sr_en, sr_ex, in_sr, perr;
    logic [1:0]  htrans;
    logic [3:0]  sbe;
    logic [6:0]  busy, mode;
    logic [7:0]  enters;
    logic [31:0] haddr, hwdata, hrdata, gcv;
    int          n_errors, total_checks;

    sdram_mode_power_control dut_u (
        .ref_clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
        .hardware_stop_input_in(stop), .suspend_status_input_in(1'b0),
        .alt_clock_input_pin_in(1'b1), .cpu_s3_in(s3), .display_shutter_in(shut),
        .cpu_special_cycle_in(cpu_sc), .sysmem_busy_in(busy[6]), .fb_busy_in(busy[5]),
        .seq_busy_in(busy[4]), .arb_busy_in(busy[3]), .chan_a_busy_in(busy[2]),
        .chan_a_seq_busy_in(busy[1]), .chan_a_arb_busy_in(busy[0]), .client_req_in(creq),
        .client_accept_out(cacc), .side_wr_in(swr), .side_be_in(sbe), .side_wr_out(swr_o),
        .cke_out(cke), .mem_oe_b_out(oe_b), .dll_reset_out(dll), .selfref_enter_out(sr_en),
        .selfref_exit_out(sr_ex), .mode_state_out(mode), .debug_group_out(),
        .debug_bus_out());
    sdram_dev_model mem_u (.clk_in(clk), .rst_b_in(rst_b), .cke_in(cke), .enter_in(sr_en),
        .exit_in(sr_ex), .in_sr_out(in_sr), .enters_out(enters), .err_out(perr));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Address then data phase, each held until hready high
    task automatic xfer(input logic w, input logic [29:0] i, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        hwr <= w;
        haddr <= {i, 2'b00};
        htrans <= 2'h2;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            @(posedge clk);
            while (hrdy !== 1'b1 && n < 20) begin
                @(posedge clk);
                n++;
            end
            if (hrdy !== 1'b1) begin
                n_errors++;
                report_and_stop();
            end
            htrans <= 2'h0;
            hwdata <= d;
        end
        r = hrdata;
    endtask

    task automatic wr(input logic [29:0] i, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, i, d, x);
    endtask

    task automatic rd(input logic [29:0] i, output logic [31:0] d);
        xfer(1'b0, i, 32'h0000_0000, d);
    endtask

    task automatic wait_mode(input logic [6:0] st, input int lim);
        int n;
        n = 0;
        while (mode !== st && n < lim) begin
            tick(1);
            n++;
        end
        chk("mode", {25'h0, mode}, {25'h0, st});
        if (mode !== st) report_and_stop();
    endtask

    task automatic reset_values();
        logic [31:0] v;
        chk("reset_pins", {23'h0, cke, oe_b, mode}, {23'h0, 2'b01, PON});
        rd(`IDX_GEN_CTRL, v);
        chk("gc_reset", v, 32'h8814_8200);
        rd(`IDX_GEN_CTRL2, v);
        chk("gc2_reset", v, 32'h0003_0200);
        rd(30'h3, v);
        chk("unmapped", v, 32'h0000_0000);
        {creq, swr} <= 2'b11;
        ce <= 1'b0;
        tick(1);
        chk("gate_stall", {29'h0, cacc, swr_o, hrdy}, 32'h0000_0000);
        ce <= 1'b1;
        $display("reset_values done");
    endtask

    task automatic status_bits();
        logic [31:0] v, e;
        logic [6:0]  b;
        for (int i = 0; i < 8; i++) begin
            b = 7'h01 << i;
            busy <= b;
            wr(`IDX_STATUS, 32'hFFFF_FFFF);
            rd(`IDX_STATUS, v);
            e = {12'h000, ~b[0], ~b[1], ~b[2], 1'b1, 13'h0000,
                 !(b[3] | b[5]), !(b[4] | b[5]), !(b[6] | b[5])};
            chk("status", v, e);
        end
        $display("status_bits done");
    endtask

    task automatic init_sequence();
        logic [31:0] v;
        int n;
        gcv = 32'h1114_8231;  // Short DLL times, no power-down source, not ready
        wr(`IDX_GEN_CTRL, gcv);
        tick(30);
        chk("init_hold", {23'h0, cke, oe_b, mode}, {23'h0, 2'b01, INIT});
        rd(`IDX_STATUS, v);
        chk("init_busy", {31'h0, v[16]}, 32'h0000_0000);
        gcv[2] = 1'b1;
        wr(`IDX_GEN_CTRL, gcv);
        n = 0;
        while (dll !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        chk("settle", {31'h0, n >= 16}, 32'h0000_0001);
        n = 0;
        while (dll === 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        chk("dll_width", n, 32'h0000_0041);
        wait_mode(OPER, 200);
        rd(`IDX_STATUS, v);
        chk("init_ready", {31'h0, v[16]}, 32'h0000_0001);
        $display("init_sequence done");
    endtask

    task automatic client_gating();
        chk("gate_closed", {30'h0, cacc, swr_o}, 32'h0000_0000);
        wr(`IDX_GEN_CTRL2, 32'h8003_0200);
        tick(1);
        chk("empty_drop", {30'h0, cacc, swr_o}, 32'h0000_0002);
        sbe <= 4'hF;
        tick(1);
        chk("side_pass", {31'h0, swr_o}, 32'h0000_0001);
        sbe <= 4'h0;
        wr(`IDX_GEN_CTRL2, 32'h8003_0000);
        tick(1);
        chk("empty_keep", {31'h0, swr_o}, 32'h0000_0001);
        $display("client_gating done");
    endtask

    task automatic park_and_wake();
        busy <= 7'h20;
        stop <= 1'b1;
        gcv[6] = 1'b1;
        wr(`IDX_GEN_CTRL, gcv);
        tick(20);
        chk("park_drain", {25'h0, mode}, {25'h0, PKG});
        busy <= 7'h00;
        wait_mode(PKD, 50);
        tick(20);
        chk("parked_sr", {24'h0, in_sr, mode}, {24'h0, 1'b1, PKD});
        stop <= 1'b0;
        wait_mode(WAKE, 20);
        tick(30);
        chk("wake_hold", {25'h0, mode}, {25'h0, WAKE});
        gcv[3] = 1'b1;
        wr(`IDX_GEN_CTRL, gcv);
        wait_mode(OPER, 200);
        tick(20);
        chk("one_shot", {24'h0, in_sr, mode}, {24'h0, 1'b0, OPER});
        gcv[6] = 1'b0;
        $display("park_and_wake done");
    endtask

    // All sources, both event kinds, then skip and inhibit
    task automatic powerdown_sources();
        logic [31:0] v;
        logic [7:0]  e0;
        logic [1:0]  s;
        logic        cpu, skip, inh, ex, left, fl;
        for (int k = 0; k < 10; k++) begin
            s = k[3] ? 2'h0 : k[1:0];
            cpu = k[2];
            {skip, inh} = {k == 8, k == 9};
            ex = !inh && (cpu ? (s == 2'h1 || s == 2'h2) : (s == 2'h0 || s == 2'h2));
            v = {gcv[31:20], skip, gcv[18:9], inh, gcv[7:6], s, gcv[3:0]};
            e0 = enters;
            wr(`IDX_GEN_CTRL, v);
            cpu_sc <= cpu;
            stop <= !cpu;
            tick(1);
            cpu_sc <= 1'b0;
            {left, fl} = 2'b01;
            repeat (40) begin
                tick(1);
                if (mode !== OPER) left = 1'b1;
                if (mode === PKD && oe_b !== 1'b1) fl = 1'b0;
            end
            stop <= 1'b0;
            wait_mode(OPER, 300);
            chk("pd_source", {31'h0, left}, {31'h0, ex});
            chk("pd_float", {31'h0, fl}, 32'h0000_0001);
            chk("pd_selfref", {24'h0, enters - e0}, {31'h0, ex && !skip});
        end
        $display("powerdown_sources done");
    endtask

    task automatic dynamic_selfref();
        int n;
        wr(`IDX_GEN_CTRL, {gcv[31:16], 4'h2, 1'b1, gcv[10:0]});
        {s3, shut} <= 2'b11;
        n = 0;
        while (mode !== DSR && n < 60) begin
            tick(1);
            n++;
        end
        chk("dyn_delay", {31'h0, n >= 9 && n <= 14}, 32'h0000_0001);
        tick(1);
        chk("dyn_sr", {31'h0, in_sr}, 32'h0000_0001);
        s3 <= 1'b0;
        wait_mode(OPER, 20);
        tick(2);
        chk("dyn_exit", {30'h0, in_sr, perr}, 32'h0000_0000);
        $display("dynamic_selfref done");
    endtask

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        {hsel, hwr, stop, cpu_sc, s3, shut, creq, swr} = 8'h00;
        htrans = 2'h0;
        sbe = 4'h0;
        busy = 7'h00;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        n_errors = 0;
        total_checks = 0;
        tick(20);
        rst_b <= 1'b1;
        tick(1);
        reset_values();
        status_bits();
        init_sequence();
        client_gating();
        park_and_wake();
        powerdown_sources();
        dynamic_selfref();
        report_and_stop();
    end
endmodule // sdram_mode_power_control_tb
